// [spm_core.sv]
// Function
// - Dual mode: send on out, receive both
// - Even bits from out, odd from in
// - Merged dual byte loads receive holding
// - Out line bidirectional in half, dual
// - Direction never flips mid byte
// - Idle direction follows select bit
// - Sample direction select on final bit
// - Capture direction on shift register load
// - Clock toggles on underflow while shifting
// - Idle clock rests at idle level
// - Source select picks fast or slow tick
// - Frequency is half reference over preload
// - Zero preload: fast clock, full rate
// - Idle level setting inverts generator output
// - Separate receive and transmit phase bits
// - Receive phase selects sampling edge
// - Transmit phase selects launch edge
`include "spm_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module spm_core #(
  parameter int PRE_W = 6
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [7:0]        tx_data,
  input  wire logic              tx_wr,
  input  wire logic              line_direction_select,
  input  wire spm_pkg::spm_path_t input_path_select,
  input  wire logic              clock_source_select,
  input  wire logic              clock_idle_level,
  input  wire logic              receive_phase,
  input  wire logic              transmit_phase,
  input  wire logic              lsb_first,
  input  wire logic [PRE_W-1:0]  preload,
  input  wire logic              slow_clk,
  input  wire logic              serial_in_line,
  input  wire logic              serial_out_i,
  output logic                   serial_out_o,
  output logic                   serial_out_oe_n,
  output logic                   spi_clk,
  output logic [7:0]             rx_data,
  output logic                   rx_valid,
  output logic                   tx_empty,
  output logic                   busy
);
  import spm_pkg::*;

  if (PRE_W < 1 || PRE_W > 16) begin : g_chk
    $error("spm_core: PRE_W out of range");
  end

  // Bit position in arrival order
  function automatic logic [2:0] spm_pos(input logic [2:0] j, input logic lsbf);
    spm_pos = lsbf ? j : (`SPM_BIT_TOP - j);
  endfunction : spm_pos

  // Pin synchronisers
  logic slow_s1_ff, slow_s2_ff, slow_s3_ff;
  logic sin_s1_ff, sin_s2_ff, sout_s1_ff, sout_s2_ff;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      slow_s1_ff <= 1'b0;
      slow_s2_ff <= 1'b0;
      slow_s3_ff <= 1'b0;
      sin_s1_ff  <= 1'b0;
      sin_s2_ff  <= 1'b0;
      sout_s1_ff <= 1'b0;
      sout_s2_ff <= 1'b0;
    end
    else
    begin
      slow_s1_ff <= slow_clk;
      slow_s2_ff <= slow_s1_ff;
      slow_s3_ff <= slow_s2_ff;
      sin_s1_ff  <= serial_in_line;
      sin_s2_ff  <= sin_s1_ff;
      sout_s1_ff <= serial_out_i;
      sout_s2_ff <= sout_s1_ff;
    end
  end

  // Engine state
  spm_state_t       state_ff, nxt_state;
  logic [7:0]       hold_ff, nxt_hold, tsr_ff, nxt_tsr, rsr_ff, nxt_rsr;
  logic [7:0]       rx_data_ff, nxt_rx_data;
  logic             hold_full_ff, nxt_hold_full;
  logic [3:0]       edge_ff, nxt_edge, last_ff, nxt_last;
  logic [PRE_W-1:0] cnt_ff, nxt_cnt, reload;
  logic             gen_ff, nxt_gen, dir_ff, nxt_dir, pend_ff, nxt_pend;
  logic             dual_rx_ff, nxt_dual_rx, rx_line_ff, nxt_rx_line;
  logic             full_ff, nxt_full, out_ff, nxt_out, oe_n_ff, nxt_oe_n;
  logic             spi_clk_ff, nxt_spi_clk, rx_valid_ff, nxt_rx_valid;
  logic             tx_empty_ff, busy_ff;
  logic             tick, uflow, lead, trail, byte_end, load_go, samp, shifting;
  logic [2:0]       j, k;

  // Divider, edges, shift and direction control
  always_comb
  begin
    shifting = (state_ff == SPM_SHIFT);
    reload   = (preload == '0) ? '0 : preload - 1'b1;
    // Zero preload forces the fast clock
    tick = (preload == '0) || !clock_source_select || (slow_s2_ff && !slow_s3_ff);
    uflow    = shifting && tick && (cnt_ff == '0);
    lead     = uflow && !gen_ff;
    trail    = uflow && gen_ff;
    byte_end = trail && (edge_ff == last_ff);
    load_go  = hold_full_ff && (!shifting || byte_end);
    nxt_state     = state_ff;
    nxt_hold      = hold_ff;
    nxt_hold_full = hold_full_ff;
    nxt_tsr       = tsr_ff;
    nxt_rsr       = rsr_ff;
    nxt_edge      = edge_ff;
    nxt_last      = last_ff;
    nxt_cnt       = cnt_ff;
    nxt_gen       = gen_ff;
    nxt_dir       = dir_ff;
    nxt_pend      = pend_ff;
    nxt_dual_rx   = dual_rx_ff;
    nxt_rx_line   = rx_line_ff;
    nxt_full      = full_ff;
    nxt_out       = out_ff;
    nxt_rx_data   = rx_data_ff;
    nxt_rx_valid  = 1'b0;
    // Receive sampling edge
    samp = receive_phase ? trail : lead;
    j    = edge_ff[3:1];
    k    = edge_ff[3:1];
    if (shifting)
    begin
      if (tick)
      begin
        nxt_cnt = (cnt_ff == '0) ? reload : cnt_ff - 1'b1;
      end
      if (uflow)
      begin
        nxt_gen  = !gen_ff;
        nxt_edge = edge_ff + 1'b1;
      end
      if (samp && dual_rx_ff)
      begin
        // Two bits per clock: even on out line, odd on in line
        if (lsb_first)
        begin
          nxt_rsr[{j[1:0], 1'b0}] = sout_s2_ff;
          nxt_rsr[{j[1:0], 1'b1}] = sin_s2_ff;
        end
        else
        begin
          nxt_rsr[{~j[1:0], 1'b1}] = sin_s2_ff;
          nxt_rsr[{~j[1:0], 1'b0}] = sout_s2_ff;
        end
      end
      else if (samp)
      begin
        nxt_rsr[spm_pos(j, lsb_first)] = rx_line_ff ? sout_s2_ff : sin_s2_ff;
      end
      // Launch edge per transmit phase
      if (!transmit_phase && trail && !byte_end)
      begin
        nxt_out = tsr_ff[spm_pos(k + 3'h1, lsb_first)];
      end
      else if (transmit_phase && lead)
      begin
        nxt_out = tsr_ff[spm_pos(k, lsb_first)];
      end
      // Direction for the idle cycle after the byte, sampled on the final bit
      if (lead && (edge_ff == last_ff - 4'h1))
      begin
        nxt_pend = line_direction_select;
      end
      if (byte_end)
      begin
        nxt_rx_data  = nxt_rsr;
        nxt_rx_valid = 1'b1;
        nxt_state    = SPM_IDLE;
        nxt_gen      = 1'b0;
        nxt_dir      = pend_ff;
      end
    end
    else
    begin
      nxt_cnt  = reload;
      nxt_gen  = 1'b0;
      nxt_dir  = line_direction_select;
      nxt_full = (input_path_select == `SPM_PATH_FULL);
    end
    if (load_go)
    begin
      nxt_state     = SPM_SHIFT;
      nxt_tsr       = hold_ff;
      nxt_hold_full = 1'b0;
      nxt_edge      = `SPM_EDGE_RST;
      nxt_gen       = 1'b0;
      nxt_cnt       = reload;
      nxt_dir       = line_direction_select;
      nxt_full      = (input_path_select == `SPM_PATH_FULL);
      nxt_dual_rx   = (input_path_select == `SPM_PATH_DUAL) && !line_direction_select;
      nxt_rx_line   = (input_path_select != `SPM_PATH_FULL) && !line_direction_select;
      nxt_last      = nxt_dual_rx ? `SPM_LAST_DUAL : `SPM_LAST_SGL;
      if (!transmit_phase)
      begin
        nxt_out = hold_ff[spm_pos(`SPM_BIT_ZERO, lsb_first)];
      end
    end
    // Holding register accepts a write when empty or in the cycle it loads the shift register
    if (tx_wr && !nxt_hold_full && (!hold_full_ff || load_go))
    begin
      nxt_hold      = tx_data;
      nxt_hold_full = 1'b1;
    end
    // Drive the line in full duplex or when the direction is output
    nxt_oe_n    = !(nxt_full || nxt_dir);
    nxt_spi_clk = nxt_gen ^ clock_idle_level;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff     <= SPM_IDLE;
      hold_ff      <= `SPM_BYTE_RST;
      hold_full_ff <= 1'b0;
      tsr_ff       <= `SPM_BYTE_RST;
      rsr_ff       <= `SPM_BYTE_RST;
      rx_data_ff   <= `SPM_BYTE_RST;
      edge_ff      <= `SPM_EDGE_RST;
      last_ff      <= `SPM_LAST_SGL;
      cnt_ff       <= '0;
      gen_ff       <= 1'b0;
      dir_ff       <= 1'b0;
      pend_ff      <= 1'b0;
      dual_rx_ff   <= 1'b0;
      rx_line_ff   <= 1'b0;
      full_ff      <= 1'b1;
      out_ff       <= 1'b0;
      oe_n_ff      <= 1'b0;
      spi_clk_ff   <= 1'b0;
      rx_valid_ff  <= 1'b0;
      tx_empty_ff  <= 1'b1;
      busy_ff      <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      hold_ff      <= nxt_hold;
      hold_full_ff <= nxt_hold_full;
      tsr_ff       <= nxt_tsr;
      rsr_ff       <= nxt_rsr;
      rx_data_ff   <= nxt_rx_data;
      edge_ff      <= nxt_edge;
      last_ff      <= nxt_last;
      cnt_ff       <= nxt_cnt;
      gen_ff       <= nxt_gen;
      dir_ff       <= nxt_dir;
      pend_ff      <= nxt_pend;
      dual_rx_ff   <= nxt_dual_rx;
      rx_line_ff   <= nxt_rx_line;
      full_ff      <= nxt_full;
      out_ff       <= nxt_out;
      oe_n_ff      <= nxt_oe_n;
      spi_clk_ff   <= nxt_spi_clk;
      rx_valid_ff  <= nxt_rx_valid;
      tx_empty_ff  <= !nxt_hold_full;
      busy_ff      <= (nxt_state == SPM_SHIFT);
    end
  end

  // Output pins and status
  assign serial_out_o    = out_ff;
  assign serial_out_oe_n = oe_n_ff;
  assign spi_clk         = spi_clk_ff;
  assign rx_data         = rx_data_ff;
  assign rx_valid        = rx_valid_ff;
  assign tx_empty        = tx_empty_ff;
  assign busy            = busy_ff;

  // Checks on the engine
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_load;
    load_go;
  endsequence
  sequence s_end;
    byte_end;
  endsequence

  a_dir_load: assert property (s_load |=> dir_ff == $past(line_direction_select))
    else $error("direction not captured at load");
  a_dir_hold: assert property (shifting && $past(shifting) && !$past(load_go)
                               && !$past(byte_end) |-> $stable(dir_ff))
    else $error("direction changed mid byte");
  a_dir_idle: assert property (!shifting && $past(!shifting)
                               |-> dir_ff == $past(line_direction_select))
    else $error("idle direction not following select");
  a_pend_samp: assert property (lead && edge_ff == last_ff - 4'h1
                                |=> pend_ff == $past(line_direction_select))
    else $error("final bit direction not sampled");
  a_clk_idle: assert property (!shifting && $past(!shifting)
                               |-> spi_clk == $past(clock_idle_level))
    else $error("idle clock level wrong");
  a_clk_toggle: assert property (shifting && $past(shifting) && $stable(clock_idle_level)
                                 && $changed(spi_clk) |-> $past(uflow))
    else $error("clock toggled without underflow");
  a_fast_rate: assert property (shifting && preload == '0 |-> uflow)
    else $error("zero reload not at full rate");
  a_rx_load: assert property (s_end |=> rx_valid && rx_data == $past(nxt_rsr))
    else $error("receive byte not loaded");
  a_byte_len: assert property (byte_end && !dual_rx_ff |-> edge_ff == `SPM_LAST_SGL)
    else $error("single byte not sixteen edges");
  a_dual_len: assert property (byte_end && dual_rx_ff |-> edge_ff == `SPM_LAST_DUAL)
    else $error("dual byte not eight edges");
  a_oe_dir: assert property (!full_ff && !dir_ff |-> serial_out_oe_n)
    else $error("out line driven while input");
endmodule : spm_core
`default_nettype wire

// [spm_cfg.svh]
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
// Input path select codes
`define SPM_PATH_FULL 2'h0
`define SPM_PATH_HALF 2'h1
`define SPM_PATH_DUAL 2'h2
// Index of the final clock edge of a byte
`define SPM_LAST_SGL  4'hF
`define SPM_LAST_DUAL 4'h7
// Byte and counter constants
`define SPM_BYTE_RST  8'h00
`define SPM_EDGE_RST  4'h0
`define SPM_BIT_ZERO  3'h0
`define SPM_BIT_TOP   3'h7
`endif

// [spm_pkg.sv]
package spm_pkg;
  // Shift engine states, one-hot
  typedef enum logic [1:0] {
    SPM_IDLE  = 2'b01,
    SPM_SHIFT = 2'b10
  } spm_state_t;
  // Input path select field
  typedef logic [1:0] spm_path_t;
endpackage : spm_pkg

// [spm_slave.sv]
`timescale 1ns/10ps
`default_nettype none
module spm_slave (
  input  wire logic       clk,
  input  wire logic       sclk,
  input  wire logic       sel,
  input  wire logic       dual,
  input  wire logic       lsbf,
  input  wire logic       smp,
  input  wire logic [7:0] sbyte,
  input  wire logic       mosi,
  output logic            d_in,
  output logic            d_out,
  output logic [7:0]      cap
);
  int   k;
  logic got;
  initial
  begin
    d_in = 0;
    d_out = 0;
    cap = 0;
    k = 0;
    got = 0;
  end
  // Current bits, or a pattern that changes while released
  always @(posedge clk)
    if (!sel)
    begin
      d_in  <= ~d_in;
      d_out <= ~d_out;
    end
    else if (dual)
    begin
      d_in  <= sbyte[lsbf ? 2*(k%4)+1 : 7-2*(k%4)];
      d_out <= sbyte[lsbf ? 2*(k%4) : 6-2*(k%4)];
    end
    else
    begin
      d_in  <= sbyte[lsbf ? k%8 : 7-k%8];
      d_out <= sbyte[lsbf ? k%8 : 7-k%8];
    end
  // Release restarts the bit count
  always @(negedge sel)
  begin
    k = 0;
    got = 0;
  end
  // Capture on sampling edge, advance on the following edge; only real clock edges count
  always @(sclk)
    if (sel)
    begin
      if (sclk == smp)
      begin
        cap = {cap[6:0], mosi};
        got = 1;
      end
      else if (got)
      begin
        k = k + 1;
        got = 0;
      end
    end
endmodule : spm_slave
`default_nettype wire

// [spm_core_tb.sv]
`include "spm_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module spm_core_tb;
  import spm_pkg::*;
  logic        ref_clk = 0, rst = 1, tx_wr = 0, dir = 0, css = 0, slow_clk = 0;
  logic        cpol = 0, rph = 0, tph = 0, lsbf = 0, sel = 0;
  logic [7:0]  tx_data = 0, sbyte = 0, rx_data, cap;
  logic [5:0]  preload = 4;
  spm_path_t   path = `SPM_PATH_FULL;
  logic        so_o, oe_n, sclk, rx_valid, tx_empty, busy, din, dout;
  wire logic   pin = oe_n ? dout : so_o;
  logic [31:0] rs = 32'h534B4A22;
  logic [31:0] r;
  int          mismatches = 0, comparisons = 0, e;
  int          exq[$];
  int          pv[4] = '{0, 1, 3, 2};
  int          cv[4] = '{1, 0, 0, 1};
  int          ev[4] = '{1, 1, 3, 50};
  time         t0;

  spm_core i_spm_core (.ref_clk(ref_clk), .rst(rst), .tx_data(tx_data), .tx_wr(tx_wr),
    .line_direction_select(dir), .input_path_select(path), .clock_source_select(css),
    .clock_idle_level(cpol), .receive_phase(rph), .transmit_phase(tph), .lsb_first(lsbf),
    .preload(preload), .slow_clk(slow_clk), .serial_in_line(din), .serial_out_i(pin),
    .serial_out_o(so_o), .serial_out_oe_n(oe_n), .spi_clk(sclk), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_empty(tx_empty), .busy(busy));
  spm_slave i_spm_slave (.clk(ref_clk), .sclk(sclk), .sel(sel), .dual(path == `SPM_PATH_DUAL),
    .lsbf(lsbf), .smp(~(cpol ^ rph)), .sbyte(sbyte), .mosi(pin), .d_in(din), .d_out(dout),
    .cap(cap));

  // Clocks: system and unrelated slow reference
  always #10 ref_clk = ~ref_clk;
  initial
  begin
    #7;
    forever #250 slow_clk = ~slow_clk;
  end

  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  task tick;
    @(posedge ref_clk);
    #1;
  endtask : tick

  task chk(input string n, input logic [7:0] s, input logic [7:0] x);
    comparisons++;
    if (s !== x)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // One byte: slave selected, write holding, wait for byte end
  task xfer(input logic [7:0] t, input logic [7:0] s, input int x);
    int n;
    sbyte = s;
    sel = 1;
    exq.push_back(x);
    tx_data = t;
    tx_wr = 1;
    tick;
    tx_wr = 0;
    chk("tx_empty_wr", 8'(tx_empty), 8'h00);
    n = 0;
    while (busy !== 1'b1 && n < 9)
    begin
      tick;
      n++;
    end
    while (busy === 1'b1 && n < 5000)
    begin
      tick;
      n++;
    end
    chk("tx_empty_end", 8'(tx_empty), 8'h01);
    chk("busy_end", 8'(busy), 8'h00);
    tick;
    tick;
    sel = 0;
  endtask : xfer

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // Reference queue checks every received byte whose expected value is not -1
  always @(posedge ref_clk)
    if (rx_valid === 1'b1)
    begin
      e = exq.size() ? exq.pop_front() : 999;
      if (e >= 0) chk("rx_data", rx_data, e[7:0]);
    end

  initial
  begin
    #1_500_000;
    mismatches++;
    test_done;
  end

  initial
  begin
    repeat (4) tick;
    rst = 0;
    tick;
    // All polarity, phase and bit orders in full duplex
    for (int m = 0; m < 16; m++)
    begin
      {lsbf, cpol, rph, tph} = m[3:0];
      tick;
      tick;
      chk("idle_clk", 8'(sclk), 8'(cpol));
      r = rnd();
      xfer(r[7:0], r[15:8], r[15:8]);
      if (rph == tph && !lsbf) chk("tx_bits", cap, r[7:0]);
    end
    $display("test modes done");
    // Dual read, direction select toggled mid byte
    {lsbf, cpol, rph, tph} = 4'h0;
    path = `SPM_PATH_DUAL;
    for (int m = 0; m < 2; m++)
    begin
      lsbf = m[0];
      dir = 0;
      tick;
      tick;
      chk("oe_idle", 8'(oe_n), 8'h01);
      r = rnd();
      fork
        xfer(r[7:0], r[15:8], r[15:8]);
        begin
          repeat (20) tick;
          dir = 1;
          repeat (10) tick;
          chk("oe_mid", 8'(oe_n), 8'h01);
          dir = 0;
        end
      join
    end
    // Dual transmit on the out line
    lsbf = 0;
    dir = 1;
    tick;
    tick;
    chk("oe_tx", 8'(oe_n), 8'h00);
    r = rnd();
    xfer(r[7:0], r[15:8], -1);
    chk("dual_tx", cap, r[7:0]);
    // Half duplex receive through the out line
    path = `SPM_PATH_HALF;
    dir = 0;
    tick;
    tick;
    chk("oe_half", 8'(oe_n), 8'h01);
    r = rnd();
    xfer(r[7:0], r[15:8], r[15:8]);
    $display("test direction done");
    // Divider half period per source and reload
    path = `SPM_PATH_FULL;
    // Second byte queued while the first shifts
    r = rnd();
    fork
      xfer(r[7:0], r[15:8], r[15:8]);
      begin
        repeat (4) tick;
        exq.push_back(r[15:8]);
        tx_data = r[23:16];
        tx_wr = 1;
        tick;
        tx_wr = 0;
        chk("tx_queued", 8'(tx_empty), 8'h00);
      end
    join
    chk("tx_queued_bits", cap, r[23:16]);
    for (int m = 0; m < 4; m++)
    begin
      preload = 6'(pv[m]);
      css = cv[m][0];
      r = rnd();
      fork
        xfer(r[7:0], r[15:8], -1);
        begin
          @(sclk);
          @(sclk);
          t0 = $time;
          @(sclk);
          chk("half_period", 8'(($time - t0) / 20), 8'(ev[m]));
        end
      join
    end
    $display("test divider done");
    chk("rx_count", 8'(exq.size()), 8'h00);
    test_done;
  end
endmodule : spm_core_tb
`default_nettype wire
